//--- core/spi_master_slave_port.sv
// Chosen here: the APB slave port.
`timescale 1ns/10ps
module spi_master_slave_port #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire spi_port_pkg::pin_s pins_in,
  output spi_port_pkg::pin_s pins_out,
  output spi_port_pkg::pin_s pins_oe_n,
  input wire logic global_irq_enable,
  input wire logic irq_ack,
  output logic irq
);
  import spi_port_pkg::*;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] index);
    byte_addr = ADDR_W'({index, 2'b00});
  endfunction

  function automatic logic [6:0] half_period(input logic dbl, input logic [1:0] rate);
    unique case ({dbl, rate})
      3'b000: half_period = HALF_DIV4;
      3'b001: half_period = HALF_DIV16;
      3'b010: half_period = HALF_DIV64;
      3'b011: half_period = HALF_DIV128;
      3'b100: half_period = HALF_DIV2;
      3'b101: half_period = HALF_DIV8;
      3'b110: half_period = HALF_DIV32;
      3'b111: half_period = HALF_DIV64;
    endcase
  endfunction

  // Shift one received bit into the byte in the selected order
  function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic lsb,
                                          input logic b);
    shift_in = lsb ? {b, cur[7:1]} : {cur[6:0], b};
  endfunction

  // Move the next transmit bit into the output position
  function automatic logic [7:0] shift_out(input logic [7:0] cur, input logic lsb);
    shift_out = lsb ? {1'b0, cur[7:1]} : {cur[6:0], 1'b0};
  endfunction

  // Bit presented on the data pin
  function automatic logic first_bit(input logic [7:0] cur, input logic lsb);
    first_bit = lsb ? cur[0] : cur[7];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode
  logic [7:0] control;
  logic double_rate;
  logic [4:0] pin_dir;
  logic done_flag;
  logic write_collision_flag_flag;
  logic done_armed;
  logic write_collision_flag_armed;
  logic [7:0] rx_buffer;
  logic [7:0] tx_hold;
  logic [7:0] tx_shift;
  logic [7:0] rx_shift;
  logic [2:0] bit_cnt;
  logic [3:0] edge_cnt;
  logic [6:0] div_cnt;
  logic sck_level;
  master_state_e state;
  logic ss_s1, ss_s2, sck_s1, sck_s2, sck_s3, mosi_s1, mosi_s2;

  logic sel_ctrl, sel_stat, sel_data, sel_dir, mapped;
  logic access, wr, rd, data_wr, data_access, stat_rd;
  logic port_en, is_master, clk_polarity_bit, clk_phase_bit, lsb_first;
  logic ss_input_low, mode_fault, slave_active;
  logic m_tick, m_lead, m_last, s_lead, s_trail, lead, trail;
  logic sample_edge, setup_edge, in_bit, busy, start, xfer_done;

  assign sel_ctrl = paddr == byte_addr(CTRL_INDEX);
  assign sel_stat = paddr == byte_addr(STATUS_INDEX);
  assign sel_data = paddr == byte_addr(DATA_INDEX);
  assign sel_dir = paddr == byte_addr(PIN_DIR_INDEX);
  assign mapped = sel_ctrl | sel_stat | sel_data | sel_dir;

  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign access = psel & penable & mapped;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign data_wr = wr & sel_data;
  assign data_access = access & sel_data;
  assign stat_rd = rd & sel_stat;

  assign port_en = control[CTRL_PORT_EN];
  assign is_master = control[CTRL_MASTER];
  assign clk_polarity_bit = control[CTRL_CLK_POLARITY_BIT];
  assign clk_phase_bit = control[CTRL_CLK_PHASE_BIT];
  assign lsb_first = control[CTRL_LSB_FIRST];

  // Read data sampled in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      if (sel_ctrl) begin
        prdata[7:0] <= control;
      end else if (sel_stat) begin
        prdata[7:0] <= {done_flag, write_collision_flag_flag, 5'h00, double_rate};
      end else if (sel_data) begin
        prdata[7:0] <= rx_buffer;
      end else if (sel_dir) begin
        prdata[4:0] <= pin_dir;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= CTRL_RESET;
    end else begin
      if (wr && sel_ctrl) begin
        control <= pwdata[7:0];
      end
      if (mode_fault) begin
        control[CTRL_MASTER] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      double_rate <= STATUS_RESET[STAT_DOUBLE];
      pin_dir <= PIN_DIR_RESET[4:0];
    end else begin
      if (wr && sel_stat) begin
        double_rate <= pwdata[STAT_DOUBLE];
      end
      if (wr && sel_dir) begin
        pin_dir <= pwdata[4:0] & PIN_DIR_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag <= STATUS_RESET[STAT_DONE];
      write_collision_flag_flag <= STATUS_RESET[STAT_WRITE_COLLISION_FLAG];
      done_armed <= 1'b0;
      write_collision_flag_armed <= 1'b0;
    end else begin
      if (xfer_done || mode_fault) begin
        done_flag <= 1'b1;
      end else if (irq_ack || (data_access && (done_armed || write_collision_flag_armed))) begin
        done_flag <= 1'b0;
      end
      if (data_wr && busy) begin
        write_collision_flag_flag <= 1'b1;
      end else if (data_access && write_collision_flag_armed) begin
        write_collision_flag_flag <= 1'b0;
      end
      if (stat_rd) begin
        // Arm only on flags software actually saw in the captured read data
        done_armed <= prdata[STAT_DONE];
        write_collision_flag_armed <= prdata[STAT_WRITE_COLLISION_FLAG];
      end else if (data_access) begin
        done_armed <= 1'b0;
        write_collision_flag_armed <= 1'b0;
      end
    end
  end

  assign irq = control[CTRL_IRQ_EN] & done_flag & global_irq_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ss_s1 <= 1'b1;
      ss_s2 <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else begin
      ss_s1 <= pins_in.ss;
      ss_s2 <= ss_s1;
      sck_s1 <= pins_in.sck;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      mosi_s1 <= pins_in.mosi;
      mosi_s2 <= mosi_s1;
    end
  end

  assign ss_input_low = ~pin_dir[DIR_SS] & ~ss_s2;
  assign mode_fault = port_en & is_master & ss_input_low;
  assign slave_active = port_en & ~is_master & ~ss_s2;

  ////////////////////////////////////////////////////////////////////////////
  // Edge generation
  assign s_lead = slave_active & (clk_polarity_bit ? (~sck_s2 & sck_s3) : (sck_s2 & ~sck_s3));
  assign s_trail = slave_active & (clk_polarity_bit ? (sck_s2 & ~sck_s3) : (~sck_s2 & sck_s3));
  assign m_tick = (state == master_run) &&
                  (div_cnt == half_period(double_rate, control[1:0]) - 7'h01);
  assign m_lead = m_tick & ~edge_cnt[0];
  assign m_last = m_tick & (edge_cnt == LAST_EDGE);
  assign lead = is_master ? m_lead : s_lead;
  assign trail = is_master ? (m_tick & edge_cnt[0]) : s_trail;
  assign sample_edge = clk_phase_bit ? trail : lead;
  assign setup_edge = clk_phase_bit ? lead : trail;
  assign in_bit = is_master ? pins_in.miso : mosi_s2;

  assign busy = (state == master_run) | (slave_active & (bit_cnt != 3'h0));
  assign start = data_wr & ~busy & port_en & is_master & ~mode_fault;
  assign xfer_done = is_master ? m_last : (sample_edge & (bit_cnt == LAST_BIT));

  ////////////////////////////////////////////////////////////////////////////
  // Master clock generator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= master_idle;
      div_cnt <= 7'h00;
      edge_cnt <= 4'h0;
      sck_level <= 1'b0;
    end else begin
      unique case (state)
        master_idle: begin
          div_cnt <= 7'h00;
          edge_cnt <= 4'h0;
          sck_level <= clk_polarity_bit;
          if (start) begin
            state <= master_run;
          end
        end
        master_run: begin
          if (mode_fault || !port_en || !is_master) begin
            state <= master_idle;
          end else if (m_tick) begin
            div_cnt <= 7'h00;
            sck_level <= ~sck_level;
            edge_cnt <= edge_cnt + 4'h1;
            if (m_last) begin
              state <= master_idle;
            end
          end else begin
            div_cnt <= div_cnt + 7'h01;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift registers and receive buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_hold <= 8'h00;
      tx_shift <= 8'h00;
      rx_shift <= 8'h00;
      bit_cnt <= 3'h0;
      rx_buffer <= 8'h00;
    end else begin
      if (data_wr && !busy) begin
        tx_hold <= pwdata[7:0];
        tx_shift <= pwdata[7:0];
      end else if (!is_master && (ss_s2 || !port_en)) begin
        tx_shift <= tx_hold;
      end else if (setup_edge && bit_cnt != 3'h0) begin
        tx_shift <= shift_out(tx_shift, lsb_first);
      end
      if (start || (!is_master && ss_s2) || state == master_idle && is_master) begin
        bit_cnt <= 3'h0;
        rx_shift <= 8'h00;
      end else if (sample_edge) begin
        bit_cnt <= bit_cnt + 3'h1;
        rx_shift <= shift_in(rx_shift, lsb_first, in_bit);
      end
      // In slave mode, or with trailing-edge sampling, the last bit arrives in the done cycle itself
      if (xfer_done) begin
        rx_buffer <= sample_edge ? shift_in(rx_shift, lsb_first, in_bit) : rx_shift;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive; an enable low means the pin is driven
  always_comb begin
    pins_out.sck = (state == master_run) ? sck_level : clk_polarity_bit;
    pins_out.mosi = first_bit(tx_shift, lsb_first);
    pins_out.miso = first_bit(tx_shift, lsb_first);
    pins_out.ss = pin_dir[SS_LEVEL];
    pins_oe_n.sck = ~(port_en & is_master & pin_dir[DIR_SCK]);
    pins_oe_n.mosi = ~(port_en & is_master & pin_dir[DIR_MOSI]);
    pins_oe_n.miso = ~(slave_active & pin_dir[DIR_MISO]);
    pins_oe_n.ss = ~(port_en & is_master & pin_dir[DIR_SS]);
  end

endmodule

//--- shared/spi_port_pkg.sv
package spi_port_pkg;

  // Register indices; the bus byte address is four times the index
  localparam logic [7:0] CTRL_INDEX = 8'h2c;
  localparam logic [7:0] STATUS_INDEX = 8'h2d;
  localparam logic [7:0] DATA_INDEX = 8'h2e;
  localparam logic [7:0] PIN_DIR_INDEX = 8'h2f;

  // Control register fields
  localparam int unsigned CTRL_IRQ_EN = 7;
  localparam int unsigned CTRL_PORT_EN = 6;
  localparam int unsigned CTRL_LSB_FIRST = 5;
  localparam int unsigned CTRL_MASTER = 4;
  localparam int unsigned CTRL_CLK_POLARITY_BIT = 3;
  localparam int unsigned CTRL_CLK_PHASE_BIT = 2;
  localparam int unsigned CTRL_RATE_HI = 1;
  localparam int unsigned CTRL_RATE_LO = 0;

  // Status register fields
  localparam int unsigned STAT_DONE = 7;
  localparam int unsigned STAT_WRITE_COLLISION_FLAG = 6;
  localparam int unsigned STAT_DOUBLE = 0;

  // Pin direction register fields
  localparam int unsigned DIR_MOSI = 0;
  localparam int unsigned DIR_MISO = 1;
  localparam int unsigned DIR_SCK = 2;
  localparam int unsigned DIR_SS = 3;
  localparam int unsigned SS_LEVEL = 4;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] PIN_DIR_RESET = 8'h00;
  localparam logic [4:0] PIN_DIR_MASK = 5'h1f;

  // Half periods of SCK in system clocks, per divisor
  localparam logic [6:0] HALF_DIV2 = 7'h01;
  localparam logic [6:0] HALF_DIV4 = 7'h02;
  localparam logic [6:0] HALF_DIV8 = 7'h04;
  localparam logic [6:0] HALF_DIV16 = 7'h08;
  localparam logic [6:0] HALF_DIV32 = 7'h10;
  localparam logic [6:0] HALF_DIV64 = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;

  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss;
  } pin_s;

  typedef enum logic {
    master_idle,
    master_run
  } master_state_e;

endpackage

//--- bench/spi_port_checker_asserts.sv
`timescale 1ns/10ps
module spi_port_checker #(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire spi_port_pkg::pin_s pins_in,
  input wire spi_port_pkg::pin_s pins_out,
  input wire spi_port_pkg::pin_s pins_oe_n,
  input wire logic global_irq_enable,
  input wire logic irq_ack,
  input wire logic irq
);
  import spi_port_pkg::*;
  logic [7:0] ctrl_q;
  logic [4:0] tog;
  logic sck_q;
  logic clk_polarity_bit_q;
  logic wr_acc;
  logic edge_ok;
  assign wr_acc = psel && penable && pwrite;
  // SCK moves not caused by a polarity change
  assign edge_ok = pins_out.sck != sck_q && ctrl_q[3] == clk_polarity_bit_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 8'h00;
      tog <= 5'h00;
      sck_q <= 1'b0;
      clk_polarity_bit_q <= 1'b0;
    end else begin
      sck_q <= pins_out.sck;
      clk_polarity_bit_q <= ctrl_q[3];
      if (wr_acc && paddr == 8'hb0) begin
        ctrl_q <= pwdata[7:0];
      end
      if (wr_acc && (paddr == 8'hb0 || paddr == 8'hb8)) begin
        tog <= 5'h00;
      end else if (edge_ok) begin
        tog <= tog + 5'h01;
      end
    end
  end
  ////////////////////////////////
  property p_reserved;
    psel && penable && !pwrite && paddr == 8'hb4 |-> prdata[5:1] == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");
  property p_irq_cause;
    irq |-> global_irq_enable && ctrl_q[7];
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without enables");
  property p_irq_ack;
    irq_ack |=> !irq;
  endproperty
  a_irq_ack: assert property (p_irq_ack) else $error("irq kept after ack");
  property p_slave_quiet;
    pins_in.ss [*5] |-> pins_oe_n.miso;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("miso driven");
  property p_fault;
    $fell(pins_in.ss) && pins_oe_n.ss && !pins_oe_n.sck
      |-> ##[1:6] (pins_oe_n.sck && pins_oe_n.mosi);
  endproperty
  a_fault: assert property (p_fault) else $error("pins kept after fault");
  property p_eight;
    tog <= 5'd16;
  endproperty
  a_eight: assert property (p_eight) else $error("too many sck edges");
  property p_idle;
    tog == 5'd16 |-> pins_out.sck == ctrl_q[3];
  endproperty
  a_idle: assert property (p_idle) else $error("sck idle level wrong");
  property p_setup_edge;
    edge_ok && !pins_oe_n.mosi && (pins_out.sck != ctrl_q[3]) != ctrl_q[2]
      |-> $stable(pins_out.mosi);
  endproperty
  a_setup_edge: assert property (p_setup_edge) else $error("mosi moved on sample");
  c_eight: cover property (tog == 5'd16);
  c_irq: cover property (irq);
  c_slave: cover property (!pins_in.ss && pins_oe_n.sck && !pins_oe_n.miso);
endmodule
bind spi_master_slave_port spi_port_checker #(.ADDR_W(ADDR_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pins_in(pins_in), .pins_out(pins_out), .pins_oe_n(pins_oe_n),
  .global_irq_enable(global_irq_enable), .irq_ack(irq_ack), .irq(irq));

//--- bench/spi_partner_model.sv
`timescale 1ns/10ps
module spi_partner_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic clk_polarity_bit,
  input wire logic clk_phase_bit,
  input wire logic lsb,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic [3:0] nset;
  logic [2:0] idx;
  logic bit_out;
  assign idx = 3'(nset - {3'b000, clk_phase_bit});
  assign bit_out = lsb ? tx[idx] : tx[3'd7 - idx];
  // A released line shows the inverse of the last bit
  assign miso = ss_n ? ~bit_out : bit_out;
  always @(negedge ss_n) nset = 4'h0;
  always @(sck) begin
    if (ss_n === 1'b0) begin
      if ((sck != clk_polarity_bit) != clk_phase_bit) begin
        rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
      end else begin
        nset = nset + 4'h1;
      end
    end
  end
endmodule

//--- bench/test_spi_master_slave_port.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module test_spi_master_slave_port;
  import spi_port_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, ss_drv, gie, ack, pc, ph, pl, rerr;
  logic pready, pslverr, irq, miso_w, sck_d;
  logic [1:0] mo;
  logic [4:0] togs;
  logic [7:0] paddr, txb, ptx, prx;
  logic [31:0] pwdata, prdata, rdat;
  pin_s pin_in, pout, poe;
  int num_errors, n_checks, gap, half, cyc;
  int hv[4] = '{2, 8, 16, 32};
  localparam logic [7:0] A_C = {CTRL_INDEX[5:0], 2'b00};
  localparam logic [7:0] A_S = {STATUS_INDEX[5:0], 2'b00};
  localparam logic [7:0] A_D = {DATA_INDEX[5:0], 2'b00};
  localparam logic [7:0] A_P = {PIN_DIR_INDEX[5:0], 2'b00};
  spi_master_slave_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins_in(pin_in), .pins_out(pout),
    .pins_oe_n(poe), .global_irq_enable(gie), .irq_ack(ack), .irq(irq));
  spi_partner_model u_peer (.sck(pin_in.sck), .mosi(pin_in.mosi), .ss_n(pin_in.ss),
    .clk_polarity_bit(pc), .clk_phase_bit(ph), .lsb(pl), .tx(ptx), .miso(miso_w), .rx(prx));
  // Undriven SCK and MOSI show the inverse of the last level; an undriven SS follows ss_drv
  assign pin_in = {poe.sck ? ~pout.sck : pout.sck, poe.mosi ? ~pout.mosi : pout.mosi,
    miso_w, poe.ss ? ss_drv : pout.ss};
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(negedge pclk) begin
    gap = gap + 1;
    if (pout.sck !== sck_d) begin
      half = gap;
      gap = 0;
      togs = togs + 5'd1;
    end
    sck_d = pout.sck;
  end
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      $display("MISMATCH timeout exp 0 got %0d", cyc);
      conclude();
    end
  end
  ////////////////////////////////
  task conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wait_done();
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, A_S, 8'h00);
      if (rdat[7] === 1'b1) break;
    end
  endtask
  ////////////////////////////////
  initial begin
    {psel, penable, pwrite, ack, pc, ph, pl} = '0;
    {paddr, pwdata, ptx, togs} = '0;
    {gap, cyc, num_errors, n_checks} = '0;
    ss_drv = 1'b1;
    gie = 1'b1;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_C, 8'h00);
    `CHK("control reset", 8'h00, rdat[7:0])
    apb(1'b0, A_S, 8'h00);
    `CHK("status reset", 8'h00, rdat[7:0])
    apb(1'b0, 8'hc0, 8'h00);
    `CHK("unmapped", 1'b1, rerr)
    for (int m = 0; m < 4; m++) begin
      mo = 2'(m);
      txb = 8'h96 ^ 8'(m);
      apb(1'b1, A_P, 8'h1d);
      {pc, ph} <= mo;
      pl <= ^mo;
      ptx <= 8'h5a + 8'(m);
      apb(1'b1, A_S, {7'h00, mo[1]});
      apb(1'b1, A_C, {2'b01, ^mo, 1'b1, mo, mo});
      apb(1'b1, A_P, 8'h0d);
      togs = 5'd0;
      apb(1'b1, A_D, txb);
      wait_done();
      `CHK("done", 1'b1, rdat[7])
      `CHK("reserved", 5'h00, rdat[5:1])
      `CHK("sent", txb, prx)
      `CHK("edges", 5'd16, togs)
      `CHK("half period", hv[m], half)
      apb(1'b0, A_D, 8'h00);
      `CHK("received", ptx, rdat[7:0])
      apb(1'b0, A_S, 8'h00);
      `CHK("done cleared", 1'b0, rdat[7])
    end
    apb(1'b1, A_D, 8'h81);
    apb(1'b1, A_D, 8'h7e);
    wait_done();
    `CHK("collision", 1'b1, rdat[6])
    `CHK("single buffer", 8'h81, prx)
    apb(1'b0, A_D, 8'h00);
    apb(1'b0, A_S, 8'h00);
    `CHK("flags cleared", 2'b00, rdat[7:6])
    apb(1'b1, A_C, 8'h10);
    togs = 5'd0;
    apb(1'b1, A_D, 8'h33);
    repeat (10) apb(1'b0, A_S, 8'h00);
    `CHK("disabled done", 1'b0, rdat[7])
    `CHK("disabled edges", 5'd0, togs)
    apb(1'b1, A_C, 8'hd0);
    apb(1'b1, A_P, 8'h07);
    ss_drv <= 1'b0;
    for (int i = 0; i < 20; i++) begin
      apb(1'b0, A_C, 8'h00);
      if (rdat[4] === 1'b0) break;
    end
    `CHK("master cleared", 1'b0, rdat[4])
    `CHK("sck released", 1'b1, poe.sck)
    `CHK("mosi released", 1'b1, poe.mosi)
    `CHK("miso driven", 1'b0, poe.miso)
    `CHK("fault irq", 1'b1, irq)
    apb(1'b0, A_S, 8'h00);
    `CHK("fault done", 1'b1, rdat[7])
    ack <= 1'b1;
    @(posedge pclk);
    ack <= 1'b0;
    @(posedge pclk);
    `CHK("irq cleared", 1'b0, irq)
    ss_drv <= 1'b1;
    repeat (3) apb(1'b0, A_S, 8'h00);
    `CHK("miso released", 1'b1, poe.miso)
    apb(1'b1, A_C, 8'hd0);
    apb(1'b0, A_C, 8'h00);
    `CHK("master restored", 8'hd0, rdat[7:0])
    conclude();
  end
endmodule
